// ==== verilog/aavg_top.v ====
// Sequencer 0 input select and power-of-two hardware averaging with AXI4-Lite registers
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "aavg_consts.vh"

// Function
// - Each result pushed to the FIFO is the mean of 2^exponent consecutive conversions.
// - An exponent of zero forwards each single conversion unchanged.
// - An exponent of six averages sixty-four conversions into one result.
// - The exponent is a 3-bit read/write field at bits 2:0 of the averaging register, reset 0.
// - Reserved bits are not writable and read back as zero; software preserves them.
// - The input-select register holds eight 2-bit fields, sample n at bits 4n+1:4n.
// - Each sample of a run routes the input numbered by its field to the converter.
// - Samples after the one with its last-sample flag set are never converted.
// - With the differential bit set, the field is pair i and inputs 2i, 2i+1 are used.
module aavg_top
(
    input wire aclk,
    input wire aresetn,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg conv_req,
    output reg [1:0] conv_input_sel,
    output reg conv_diff,
    input wire conv_done,
    input wire [9:0] conv_data,
    output wire res_valid,
    input wire res_ready,
    output wire [9:0] res_data
);

    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_CONV = 4'h2;
    localparam [3:0] ST_PUSH = 4'h4;
    localparam [3:0] ST_NEXT = 4'h8;

    // ****************************************
    // Register file
    // ****************************************
    reg [2:0] averaging_exponent_r;
    reg [31:0] sel0_r;
    reg [31:0] seq0_ctrl_r;
    reg aw_got_r;
    reg w_got_r;
    reg [11:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg start_r;
    wire [31:0] strb_mask;
    wire do_write;
    wire wr_hit;
    reg [31:0] rd_val;
    reg rd_hit;
    reg [3:0] state_r;
    reg [2:0] sample_r;

    assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready = !w_got_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;
    assign strb_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    assign wr_hit = (awaddr_r == `AAVG_OFF_INITIATE) || (awaddr_r == `AAVG_OFF_AVG_CTRL) ||
                    (awaddr_r == `AAVG_OFF_SEL0) || (awaddr_r == `AAVG_OFF_SEQ0_CTRL) ||
                    (awaddr_r == `AAVG_OFF_STATUS);

    // Address and data may arrive in either order
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AAVG_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_r <= 1'b1;
                awaddr_r <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `AAVG_RESP_OKAY : `AAVG_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Reserved bits are masked off on write so they stay zero
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            averaging_exponent_r <= `AAVG_AVG_RESET;
            sel0_r <= `AAVG_SEL0_RESET;
            seq0_ctrl_r <= `AAVG_CTRL_RESET;
            start_r <= 1'b0;
        end
        else
        begin
            start_r <= do_write && (awaddr_r == `AAVG_OFF_INITIATE) && wstrb_r[0] && wdata_r[0];
            if (do_write && awaddr_r == `AAVG_OFF_AVG_CTRL && wstrb_r[0])
            begin
                averaging_exponent_r <= wdata_r[2:0];
            end
            if (do_write && awaddr_r == `AAVG_OFF_SEL0)
            begin
                sel0_r <= ((wdata_r & strb_mask) | (sel0_r & ~strb_mask)) & `AAVG_SEL0_MASK;
            end
            if (do_write && awaddr_r == `AAVG_OFF_SEQ0_CTRL)
            begin
                seq0_ctrl_r <= ((wdata_r & strb_mask) | (seq0_ctrl_r & ~strb_mask)) & `AAVG_CTRL_MASK;
            end
        end
    end

    always @*
    begin
        rd_val = 32'h00000000;
        rd_hit = 1'b1;
        case ({s_axi_araddr[11:2], 2'b00})
            `AAVG_OFF_INITIATE: rd_val = 32'h00000000;
            `AAVG_OFF_AVG_CTRL: rd_val = {29'h0000000, averaging_exponent_r};
            `AAVG_OFF_SEL0: rd_val = sel0_r;
            `AAVG_OFF_SEQ0_CTRL: rd_val = seq0_ctrl_r;
            `AAVG_OFF_STATUS: rd_val = {25'h0000000, sample_r, state_r == ST_IDLE ? 1'b0 : 1'b1,
                                        3'h0};
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `AAVG_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? `AAVG_RESP_OKAY : `AAVG_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ****************************************
    // Per-sample field extraction
    // ****************************************
    wire [1:0] input_sel_sample [0:7];
    wire [7:0] end_flag;
    wire [7:0] diff_flag;
    genvar gi;
    generate
        for (gi = 0; gi < `AAVG_NUM_SAMPLES; gi = gi + 1)
        begin : g_fld
            assign input_sel_sample[gi] = sel0_r[4*gi+1:4*gi];
            assign end_flag[gi] = seq0_ctrl_r[4*gi+`AAVG_END_BIT];
            assign diff_flag[gi] = seq0_ctrl_r[4*gi+`AAVG_DIFF_BIT];
        end
    endgenerate

    // ****************************************
    // Sequencer and averager
    // ****************************************
    reg [2:0] avg_lat_r;
    reg [`AAVG_ACC_W-1:0] acc_r;
    reg [6:0] cnt_r;
    reg [9:0] avg_out_r;
    wire [6:0] cnt_last;
    wire [`AAVG_ACC_W-1:0] acc_sum;
    wire [`AAVG_ACC_W-1:0] acc_shift;
    wire buf_in_ready;
    wire buf_in_valid;

    // Exponent is latched per run; seven is not guarded and its 128-sample sum can overflow the 16-bit accumulator
    assign cnt_last = (7'h01 << avg_lat_r) - 7'h01;
    assign acc_sum = acc_r + {6'h00, conv_data};
    assign acc_shift = acc_sum >> avg_lat_r;
    assign buf_in_valid = (state_r == ST_PUSH);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= ST_IDLE;
            sample_r <= 3'h0;
            avg_lat_r <= 3'h0;
            acc_r <= 16'h0000;
            cnt_r <= 7'h00;
            avg_out_r <= 10'h000;
            conv_req <= 1'b0;
            conv_input_sel <= 2'h0;
            conv_diff <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (start_r)
                    begin
                        avg_lat_r <= averaging_exponent_r;
                        sample_r <= 3'h0;
                        acc_r <= 16'h0000;
                        cnt_r <= 7'h00;
                        conv_req <= 1'b1;
                        conv_input_sel <= input_sel_sample[0];
                        conv_diff <= diff_flag[0];
                        state_r <= ST_CONV;
                    end
                end
                ST_CONV:
                begin
                    if (conv_done)
                    begin
                        acc_r <= acc_sum;
                        cnt_r <= cnt_r + 7'h01;
                        if (cnt_r == cnt_last)
                        begin
                            conv_req <= 1'b0;
                            avg_out_r <= acc_shift[9:0];
                            state_r <= ST_PUSH;
                        end
                    end
                end
                ST_PUSH:
                begin
                    // Holding here stalls new conversions while the buffer is full
                    if (buf_in_ready)
                        state_r <= ST_NEXT;
                end
                ST_NEXT:
                begin
                    acc_r <= 16'h0000;
                    cnt_r <= 7'h00;
                    if (end_flag[sample_r] || sample_r == 3'h7)
                    begin
                        state_r <= ST_IDLE;
                    end
                    else
                    begin
                        sample_r <= sample_r + 3'h1;
                        conv_req <= 1'b1;
                        conv_input_sel <= input_sel_sample[sample_r + 3'h1];
                        conv_diff <= diff_flag[sample_r + 3'h1];
                        state_r <= ST_CONV;
                    end
                end
                default:
                begin
                    state_r <= ST_IDLE;
                    conv_req <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Two-entry result buffer
    // ****************************************
    reg [9:0] buf_mem_r [0:1];
    reg buf_wp_r;
    reg buf_rp_r;
    reg [1:0] buf_cnt_r;
    wire buf_push;
    wire buf_pop;

    assign buf_in_ready = (buf_cnt_r != 2'h2);
    assign res_valid = (buf_cnt_r != 2'h0);
    assign res_data = buf_mem_r[buf_rp_r];
    assign buf_push = buf_in_valid && buf_in_ready;
    assign buf_pop = res_valid && res_ready;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            buf_wp_r <= 1'b0;
            buf_rp_r <= 1'b0;
            buf_cnt_r <= 2'h0;
            buf_mem_r[0] <= 10'h000;
            buf_mem_r[1] <= 10'h000;
        end
        else
        begin
            if (buf_push)
            begin
                buf_mem_r[buf_wp_r] <= avg_out_r;
                buf_wp_r <= ~buf_wp_r;
            end
            if (buf_pop)
                buf_rp_r <= ~buf_rp_r;
            if (buf_push && !buf_pop)
                buf_cnt_r <= buf_cnt_r + 2'h1;
            else if (buf_pop && !buf_push)
                buf_cnt_r <= buf_cnt_r - 2'h1;
        end
    end

endmodule
`default_nettype wire

// ==== verilog/aavg_consts.vh ====
// Register map, field layout and sizes of the averaging and input-select block
`ifndef AAVG_CONSTS_VH
`define AAVG_CONSTS_VH

`define AAVG_OFF_INITIATE 12'h028
`define AAVG_OFF_AVG_CTRL 12'h030
`define AAVG_OFF_SEL0 12'h040
`define AAVG_OFF_SEQ0_CTRL 12'h044
`define AAVG_OFF_STATUS 12'h050

`define AAVG_AVG_MASK 32'h00000007
`define AAVG_SEL0_MASK 32'h33333333
`define AAVG_CTRL_MASK 32'h33333333
`define AAVG_AVG_RESET 3'h0
`define AAVG_SEL0_RESET 32'h00000000
`define AAVG_CTRL_RESET 32'h00000000

`define AAVG_DIFF_BIT 0
`define AAVG_END_BIT 1
`define AAVG_NUM_SAMPLES 8
`define AAVG_SAMPLE_W 10
`define AAVG_ACC_W 16

`define AAVG_RESP_OKAY 2'h0
`define AAVG_RESP_SLVERR 2'h2

`endif

// ==== testbench/aavg_props.sv ====
// Port checks for the averaging block
`timescale 1ns/1ps
`default_nettype none
module aavg_props
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic conv_req,
    input wire logic [1:0] conv_input_sel,
    input wire logic conv_diff,
    input wire logic res_valid,
    input wire logic res_ready,
    input wire logic [9:0] res_data
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_rvalid_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped");
    a_result_held: assert property (res_valid && !res_ready
        |=> res_valid && $stable(res_data)) else $error("result lost");
    a_select_steady: assert property (conv_req && $past(conv_req)
        |-> $stable(conv_input_sel) && $stable(conv_diff)) else $error("select moved");
    a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken early");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken early");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid) else $error("no write response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read data");
    c_result: cover property (res_valid && res_ready);
    c_stall: cover property (res_valid && !res_ready && !conv_req);
    c_diff: cover property (conv_req && conv_diff);
endmodule
bind aavg_top aavg_props aavg_props_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .conv_req, .conv_input_sel, .conv_diff,
    .res_valid, .res_ready, .res_data);
`default_nettype wire

// ==== testbench/aavg_conv_model.sv ====
// Behavioural converter core answering conversion requests
`timescale 1ns/1ps
`default_nettype none
module aavg_conv_model
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic conv_req,
    input wire logic [1:0] conv_input_sel,
    input wire logic conv_diff,
    output logic conv_done,
    output logic [9:0] conv_data
);
    logic [6:0] cnt_r;
    logic [1:0] gap_r;
    logic [9:0] val_r;
    // Data only valid with done; otherwise it flips so stale use shows
    assign conv_data = conv_done ? val_r : ~val_r;
    always @(posedge aclk)
    begin
        conv_done <= 1'b0;
        if (!aresetn)
            val_r <= 10'h0;
        if (!aresetn || !conv_req)
        begin
            cnt_r <= 7'h0;
            gap_r <= 2'h0;
        end
        else if (!conv_done && gap_r == 2'h0)
        begin
            conv_done <= 1'b1;
            // Input code plus count lets the bench predict each mean
            val_r <= {conv_diff, conv_input_sel, cnt_r};
            cnt_r <= cnt_r + 7'h1;
            gap_r <= 2'($urandom % 4);
        end
        else if (gap_r != 2'h0)
            gap_r <= gap_r - 2'h1;
    end
endmodule
`default_nettype wire

// ==== testbench/aavg_top_test.sv ====
// Self-checking bench for the averaging block
`timescale 1ns/1ps
`default_nettype none
`include "aavg_consts.vh"
module aavg_top_test;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, conv_req, conv_diff, conv_done, res_valid, res_ready, stall;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, sel, ctl;
    logic [1:0] s_axi_bresp, s_axi_rresp, conv_input_sel;
    logic [3:0] s_axi_wstrb;
    logic [9:0] conv_data, res_data;
    logic [31:0] rq[$];
    logic [9:0] dq[$];
    int mismatches, tests_run, last;
    aavg_top aavg_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_req, .conv_input_sel,
        .conv_diff, .conv_done, .conv_data, .res_valid, .res_ready, .res_data);
    aavg_conv_model aavg_conv_model_inst (.aclk, .aresetn, .conv_req, .conv_input_sel,
        .conv_diff, .conv_done, .conv_data);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Response ready rises one cycle after the handshakes, in the same cycle as bvalid, so the slave never holds its answer
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw, w;
        rq.push_back({30'h0, r});
        @(posedge aclk);
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (aw || w)
        begin
            @(posedge aclk);
            if (aw && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (w && s_axi_wready) s_axi_wvalid <= 1'b0;
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
        end
        @(posedge aclk);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        rq.push_back(d);
        rq.push_back({30'h0, r});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        @(posedge aclk);
        while (!s_axi_arready) @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        while (!s_axi_rvalid) @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        res_ready <= !stall && ($urandom % 4 != 0);
        if (s_axi_bvalid && s_axi_bready) chk({30'h0, s_axi_bresp}, rq.pop_front());
        if (s_axi_rvalid && s_axi_rready)
        begin
            chk(s_axi_rdata, rq.pop_front());
            chk({30'h0, s_axi_rresp}, rq.pop_front());
        end
        if (res_valid && res_ready) chk({22'h0, res_data}, dq.size() ? dq.pop_front() : '1);
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        final_report();
    end
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h0;
        {s_axi_rready, stall, s_axi_awaddr, s_axi_araddr} = 26'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        void'($urandom(32'h8941));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`AAVG_OFF_AVG_CTRL, 32'h0, 2'h0);
        rd(`AAVG_OFF_SEL0, 32'h0, 2'h0);
        wr(`AAVG_OFF_AVG_CTRL, 32'hfffffffe, 2'h0);
        rd(`AAVG_OFF_AVG_CTRL, 32'h6, 2'h0);
        wr(`AAVG_OFF_SEL0, 32'hffffffff, 2'h0);
        rd(`AAVG_OFF_SEL0, 32'h33333333, 2'h0);
        // Low byte only: the upper select fields must survive
        s_axi_wstrb <= 4'h1;
        wr(`AAVG_OFF_SEL0, 32'h0, 2'h0);
        s_axi_wstrb <= 4'hf;
        rd(`AAVG_OFF_SEL0, 32'h33333300, 2'h0);
        wr(12'h100, 32'h1, 2'h2);
        rd(12'h104, 32'h0, 2'h2);
        $display("register test done");
        for (int e = 0; e < 7; e++)
        begin
            sel = $urandom & 32'h33333333;
            last = (e == 2) ? 7 : $urandom % 8;
            ctl = ($urandom & 32'h11111111) | (32'h2 << (4 * last));
            for (int j = 0; j <= last; j++)
                dq.push_back({ctl[4*j], sel[4*j+:2], 7'h0} + 10'((2 ** e - 1) / 2));
            wr(`AAVG_OFF_AVG_CTRL, 32'(e), 2'h0);
            wr(`AAVG_OFF_SEL0, sel, 2'h0);
            wr(`AAVG_OFF_SEQ0_CTRL, ctl, 2'h0);
            stall <= (e == 2);
            wr(`AAVG_OFF_INITIATE, 32'h1, 2'h0);
            repeat (100) @(posedge aclk);
            stall <= 1'b0;
            while (dq.size() != 0) @(posedge aclk);
            repeat (40) @(posedge aclk);
            $display("averaging test %0d done", e);
        end
        final_report();
    end
endmodule
`default_nettype wire
